// ===== src/stp_tap.v
// Test access port of a pipelined SRAM, sampled on mclk
// Function
// - Inputs taken on rising test-clock edge, output changes on falling edge.
// - Command input sampled on rising edge; undriven reads high.
// - Instruction picks which data register sits in serial path.
// - Serial input enters register MSB, shifting toward LSB.
// - Serial output shows selected register LSB, updated on falling edge.
// - Output driver enabled only in shift states, else high impedance.
// - Five rising edges with command high reset the controller.
// - Controller reset affects memory operation only by ending a SAMPLE-Z output float.
// - Power-up resets controller internally; output starts high impedance.
// - Only one register in the serial path at a time.
// - Instruction register three bits, loads only while in the path.
// - Reset state loads the IDCODE instruction.
// - Capture-IR loads binary 01 into two low bits.
// - One-bit bypass register gives minimal serial delay.
// - Bypass bit cleared low when BYPASS takes effect.
// - With test clock held low, controller stays in reset.
// - New instruction acts only after Update-IR.
// - IDCODE captures fixed 32-bit value, shifts it in Shift-DR.
// - All-zero instruction samples and forces memory outputs high impedance.
// - SAMPLE-Z puts boundary register in path, forces outputs high impedance.
`timescale 1ns/1ps
`default_nettype none
`include "stp_consts.vh"
module stp_tap #(
  parameter [3:0]  ID_REV   = 4'h0,
  parameter [4:0]  ID_DEPTH = 5'h07,
  parameter [4:0]  ID_WIDTH = 5'h04,
  parameter [5:0]  ID_DEV   = 6'h00,
  parameter [10:0] ID_MAKER = 11'h5A5, // Arbitrary value
  parameter        BSR_W    = `STP_BSR_W
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire             tck,
  input  wire             tms,
  input  wire             tms_oe,
  input  wire             tdi,
  input  wire             tdi_oe,
  input  wire [BSR_W-1:0] ring_in,
  output reg              tdo,
  output reg              tdo_oe,
  output reg              mem_hiz,
  output wire [3:0]       tap_state
);
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  reg  tck_d;
  reg  [3:0] state;
  reg  [3:0] next_state;
  reg  [`STP_IR_W-1:0] ir_sh;
  reg  [`STP_IR_W-1:0] ir;
  reg  byp;
  reg  [`STP_ID_W-1:0] idr;
  reg  [BSR_W-1:0] bsr;
  reg  [2:0] tms_hi_cnt;
  reg  next_tdo;
  wire tck_rise;
  wire tck_fall;
  wire tms_v;
  wire tdi_v;
  wire [`STP_ID_W-1:0] id_value;
  wire shift_dr;
  wire shift_ir;
  wire sel_id;
  wire sel_bsr;
  wire sel_byp;
  wire cap_dr;
  wire cap_ir;
  wire upd_ir;
  wire tms_fifth;
  wire to_tlr;
  reg  [2:0] next_cnt;
  reg  [`STP_IR_W-1:0] next_ir_sh;
  reg  [`STP_IR_W-1:0] next_ir;
  reg  next_byp;
  reg  [`STP_ID_W-1:0] next_idr;
  reg  [BSR_W-1:0] next_bsr;
  reg  next_tdo_oe;
  localparam [31:0] TMS_LAST = `STP_RST_TMS_CNT - 1;

  // Pull-ups on undriven pins
  assign tms_v = tms_oe ? tms : 1'b1;
  assign tdi_v = tdi_oe ? tdi : 1'b1;

  stp_sync u_tck (.mclk(mclk), .rst(rst), .din(tck), .dout(tck_s));
  stp_sync #(.RST_VAL(1'b1)) u_tms (.mclk(mclk), .rst(rst), .din(tms_v), .dout(tms_s));
  stp_sync #(.RST_VAL(1'b1)) u_tdi (.mclk(mclk), .rst(rst), .din(tdi_v), .dout(tdi_s));

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;
  assign tap_state = state;

  assign id_value = {ID_REV, ID_DEPTH, ID_WIDTH, ID_DEV, ID_MAKER, 1'b1};
  assign shift_dr = (state == `STP_SDR);
  assign shift_ir = (state == `STP_SIR);
  assign sel_id   = (ir == `STP_IR_IDCODE);
  assign sel_bsr  = (ir == `STP_IR_SAMPLEZ) || (ir == `STP_IR_SAMPLE) || (ir == `STP_IR_SAMPLE2);
  assign sel_byp  = ~sel_id & ~sel_bsr;
  assign cap_dr   = (state == `STP_CDR);
  assign cap_ir   = (state == `STP_CIR);
  assign upd_ir   = (state == `STP_UIR);

  // Controller transitions
  always @* begin
    next_state = state;
    case (state)
      `STP_TLR: next_state = tms_s ? `STP_TLR : `STP_RTI;
      `STP_RTI: next_state = tms_s ? `STP_SDS : `STP_RTI;
      `STP_SDS: next_state = tms_s ? `STP_SIS : `STP_CDR;
      `STP_CDR: next_state = tms_s ? `STP_E1D : `STP_SDR;
      `STP_SDR: next_state = tms_s ? `STP_E1D : `STP_SDR;
      `STP_E1D: next_state = tms_s ? `STP_UDR : `STP_PDR;
      `STP_PDR: next_state = tms_s ? `STP_E2D : `STP_PDR;
      `STP_E2D: next_state = tms_s ? `STP_UDR : `STP_SDR;
      `STP_UDR: next_state = tms_s ? `STP_SDS : `STP_RTI;
      `STP_SIS: next_state = tms_s ? `STP_TLR : `STP_CIR;
      `STP_CIR: next_state = tms_s ? `STP_E1I : `STP_SIR;
      `STP_SIR: next_state = tms_s ? `STP_E1I : `STP_SIR;
      `STP_E1I: next_state = tms_s ? `STP_UIR : `STP_PIR;
      `STP_PIR: next_state = tms_s ? `STP_E2I : `STP_PIR;
      `STP_E2I: next_state = tms_s ? `STP_UIR : `STP_SIR;
      `STP_UIR: next_state = tms_s ? `STP_SDS : `STP_RTI;
      default:  next_state = `STP_TLR;
    endcase
  end

  // Fifth consecutive high command forces the reset state
  assign tms_fifth = tms_s && (tms_hi_cnt == TMS_LAST[2:0]);
  assign to_tlr    = tms_fifth || (next_state == `STP_TLR);

  // Consecutive rises with command high, saturating
  always @* begin
    if (!tms_s) begin
      next_cnt = 3'h0;
    end else if (tms_hi_cnt != TMS_LAST[2:0]) begin
      next_cnt = tms_hi_cnt + 3'h1;
    end else begin
      next_cnt = tms_hi_cnt;
    end
  end

  // Controller state on rising test clock
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state      <= `STP_TLR;
      tms_hi_cnt <= 3'h0;
    end else if (tck_rise) begin
      if (tms_fifth) begin
        state <= `STP_TLR;
      end else begin
        state <= next_state;
      end
      tms_hi_cnt <= next_cnt;
    end
  end

  // Instruction shift stage: capture marker, then serial load
  always @* begin
    if (cap_ir) begin
      next_ir_sh = {ir_sh[`STP_IR_W-1:2], `STP_IR_CAPTURE};
    end else if (shift_ir) begin
      next_ir_sh = {tdi_s, ir_sh[`STP_IR_W-1:1]};
    end else begin
      next_ir_sh = ir_sh;
    end
  end

  // Active instruction: default on reset entry, new code at update
  always @* begin
    if (to_tlr) begin
      next_ir = `STP_IR_IDCODE;
    end else if (upd_ir) begin
      next_ir = ir_sh;
    end else begin
      next_ir = ir;
    end
  end

  // Instruction registers
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ir_sh <= `STP_IR_IDCODE;
      ir    <= `STP_IR_IDCODE;
    end else if (tck_rise) begin
      ir_sh <= next_ir_sh;
      ir    <= next_ir;
    end
  end

  // Bypass bit
  always @* begin
    if (upd_ir && ir_sh == `STP_IR_BYPASS) begin
      next_byp = 1'b0;
    end else if (sel_byp && cap_dr) begin
      next_byp = 1'b0;
    end else if (sel_byp && shift_dr) begin
      next_byp = tdi_s;
    end else begin
      next_byp = byp;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      byp <= 1'b0;
    end else if (tck_rise) begin
      byp <= next_byp;
    end
  end

  // Identification register
  always @* begin
    if (sel_id && cap_dr) begin
      next_idr = id_value;
    end else if (sel_id && shift_dr) begin
      next_idr = {tdi_s, idr[`STP_ID_W-1:1]};
    end else begin
      next_idr = idr;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      idr <= {`STP_ID_W{1'b0}};
    end else if (tck_rise) begin
      idr <= next_idr;
    end
  end

  // Boundary ring register
  always @* begin
    if (sel_bsr && cap_dr) begin
      next_bsr = ring_in;
    end else if (sel_bsr && shift_dr) begin
      next_bsr = {tdi_s, bsr[BSR_W-1:1]};
    end else begin
      next_bsr = bsr;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      bsr <= {BSR_W{1'b0}};
    end else if (tck_rise) begin
      bsr <= next_bsr;
    end
  end

  // One register's LSB picked for the serial output
  always @* begin
    if (shift_ir) begin
      next_tdo = ir_sh[0];
    end else if (sel_id) begin
      next_tdo = idr[0];
    end else if (sel_bsr) begin
      next_tdo = bsr[0];
    end else begin
      next_tdo = byp;
    end
  end

  // Driver enable only in the two shift states
  always @* begin
    if (shift_dr || shift_ir) begin
      next_tdo_oe = 1'b1;
    end else begin
      next_tdo_oe = 1'b0;
    end
  end

  // Output and driver enable change on falling test clock
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tdo <= 1'b0;
    end else if (tck_fall) begin
      tdo <= next_tdo;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= next_tdo_oe;
    end
  end

  // Memory output float request; no other link to the memory core
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_hiz <= 1'b0;
    end else begin
      mem_hiz <= (ir == `STP_IR_SAMPLEZ);
    end
  end
endmodule
`default_nettype wire

// ===== src/stp_consts.vh
// Constants for the SRAM test access port
`ifndef STP_CONSTS_VH
`define STP_CONSTS_VH

`define STP_IR_W        3
`define STP_ID_W        32
`define STP_BSR_W       75
`define STP_RST_TMS_CNT 5

`define STP_IR_SAMPLEZ  3'h0
`define STP_IR_IDCODE   3'h1
`define STP_IR_SAMPLE2  3'h2
`define STP_IR_SAMPLE   3'h4
`define STP_IR_BYPASS   3'h7

`define STP_IR_CAPTURE  2'h1

`define STP_TLR 4'hF
`define STP_RTI 4'hC
`define STP_SDS 4'h7
`define STP_CDR 4'h6
`define STP_SDR 4'h2
`define STP_E1D 4'h1
`define STP_PDR 4'h3
`define STP_E2D 4'h0
`define STP_UDR 4'h5
`define STP_SIS 4'h4
`define STP_CIR 4'hE
`define STP_SIR 4'hA
`define STP_E1I 4'h9
`define STP_PIR 4'hB
`define STP_E2I 4'h8
`define STP_UIR 4'hD

`endif

// ===== src/stp_sync.v
// Two-stage synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module stp_sync #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input  wire mclk,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg meta;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== verification/stp_tap_properties.sv
// Assertions on the test port pins
`timescale 1ns/1ps
`default_nettype none
`include "stp_consts.vh"
module stp_props (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       tck,
  input wire logic       tms,
  input wire logic       tms_oe,
  input wire logic       tdo,
  input wire logic       tdo_oe,
  input wire logic       mem_hiz,
  input wire logic [3:0] tap_state
);
  logic       tck_d;
  logic [2:0] hi;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Rises seen with command high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tck_d <= 1'b0;
      hi <= 3'h0;
    end else begin
      tck_d <= tck;
      if (tck && !tck_d) hi <= (tms || !tms_oe) ? hi + {2'h0, hi != 3'h5} : 3'h0;
    end
  end
  reset_idle_a: assert property ($fell(rst) |-> tap_state == `STP_TLR && !tdo_oe)
    else $error("bad reset state");
  five_high_a: assert property (hi == 3'h5 |-> ##[0:6] tap_state == `STP_TLR)
    else $error("no five-high reset");
  state_rise_a: assert property ($changed(tap_state) |-> $past(tck))
    else $error("state moved off rise");
  tdo_fall_a: assert property ($changed({tdo, tdo_oe}) |-> !$past(tck))
    else $error("output moved off fall");
  oe_shift_a: assert property (tdo_oe |-> tap_state inside {`STP_SDR, `STP_SIR, `STP_E1D, `STP_E1I})
    else $error("output on outside shift");
  ir_marker_a: assert property ($rose(tdo_oe) && tap_state == `STP_SIR |-> tdo)
    else $error("capture marker lost");
  hiz_update_a: assert property ($changed(mem_hiz) |-> $past(tap_state) inside {`STP_UIR, `STP_TLR} ||
    $past(tap_state, 2) inside {`STP_UIR, `STP_TLR})
    else $error("hiz changed off update");
  tlr_quiet_a: assert property (tap_state == `STP_TLR |-> !tdo_oe ##2 !mem_hiz)
    else $error("reset state not quiet");
  ir_load_c: cover property (tap_state == `STP_UIR);
  dr_shift_c: cover property (tdo_oe && tap_state == `STP_SDR);
  hiz_on_c: cover property (mem_hiz);
endmodule
`default_nettype wire

// ===== verification/stp_tester.sv
// Board tester model driving the test port
`timescale 1ns/1ps
`default_nettype none
module stp_tester (
  input  wire logic mclk,
  input  wire logic tdo,
  output var  logic tck,
  output var  logic tms,
  output var  logic tms_oe,
  output var  logic tdi,
  output var  logic tdi_oe
);
  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tms_oe = 1'b0;
    tdi = 1'b0;
    tdi_oe = 1'b0;
  end
  // One test-clock period; released lines show the inverse level
  task automatic step(input logic m, input logic d, input logic e, output logic q);
    @(negedge mclk);
    tms = e ? m : !m;
    tms_oe = e;
    tdi = e ? d : !d;
    tdi_oe = e;
    repeat (3) @(negedge mclk);
    q = tdo;
    tck = 1'b1;
    repeat (4) @(negedge mclk);
    tck = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verification/stp_tap_bench.sv
// Bench for the test access port
`timescale 1ns/1ps
`default_nettype none
module stp_tap_bench;
  logic        mclk, rst, tck, tms, tms_oe, tdi, tdi_oe, tdo, tdo_oe, mem_hiz, q;
  logic [3:0]  tap_state;
  logic [74:0] ring = 75'h4A5A5A5A5A5A5A5A5A5;
  logic [31:0] idv = {4'h2, 5'h07, 5'h04, 6'h00, 11'h2C3, 1'b1}; // Maker code arbitrary
  logic [79:0] din, dout, cap;
  logic [7:0]  rows [8] = '{8'hCB, 8'h20, 8'h4B, 8'h01, 8'h4B, 8'h01, 8'h01, 8'h01}; // Hi-Z, length
  int          errors, comparisons, n;
  stp_tap #(.ID_REV(4'h2), .ID_MAKER(11'h2C3)) u_stp_tap (.mclk(mclk), .rst(rst), .tck(tck), .tms(tms),
    .tms_oe(tms_oe), .tdi(tdi), .tdi_oe(tdi_oe), .ring_in(ring), .tdo(tdo), .tdo_oe(tdo_oe),
    .mem_hiz(mem_hiz), .tap_state(tap_state));
  stp_tester u_stp_tester (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tms_oe(tms_oe), .tdi(tdi),
    .tdi_oe(tdi_oe));
  task automatic chk(input logic [79:0] g, input logic [79:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic walk(input logic [3:0] m, input int k);
    for (int i = 0; i < k; i++) u_stp_tester.step(m[i], 1'b1, 1'b1, q);
  endtask
  task automatic shift(input int k);
    dout = '0;
    for (int i = 0; i < k; i++) u_stp_tester.step(i == k - 1, din[i], 1'b1, dout[i]);
    walk(4'h1, 2);
  endtask
  task automatic ir_load(input int c);
    walk(4'h3, 4);
    din = 80'(c);
    shift(3);
  endtask
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #1ms;
    errors++;
    give_verdict;
  end
  initial begin
    rst = 1'b1;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    walk(4'h0, 1);
    for (int c = 0; c < 8; c++) begin
      ir_load(c);
      chk(dout & 80'h3, 80'h1);
      chk(80'(mem_hiz), 80'(rows[c][7]));
      n = rows[c][6:0];
      cap = n == 1 ? 80'h0 : n == 32 ? 80'(idv) : 80'(ring);
      walk(4'h1, 3);
      din = 80'hB;
      shift(n + 4);
      chk(dout, cap | (80'hB << n));
      $display("code %0d done", c);
    end
    ir_load(0);
    walk(4'h1, 3);
    repeat (5) u_stp_tester.step(1'b1, 1'b0, 1'b0, q);
    repeat (4) @(negedge mclk);
    chk(80'({mem_hiz, tap_state}), 80'h0F);
    $display("float reset done");
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    repeat (40) @(negedge mclk);
    chk(80'({tdo_oe, tap_state}), 80'h0F);
    walk(4'h0, 1);
    walk(4'h1, 3);
    din = 80'hB;
    shift(36);
    chk(dout, 80'(idv) | (80'hB << 32));
    $display("reset test done");
    give_verdict;
  end
endmodule
bind stp_tap stp_props u_stp_props (.mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tms_oe(tms_oe),
  .tdo(tdo), .tdo_oe(tdo_oe), .mem_hiz(mem_hiz), .tap_state(tap_state));
`default_nettype wire
